// >>> ccss_defines.svh
/*
 * Constants of the clock source select and start-up block: fuse codes,
 * control/status bit positions, reset values and start-up delay counts.
 * Assumes inclusion by the design and checker files of this block.
 */
`ifndef CCSS_DEFINES_SVH
`define CCSS_DEFINES_SVH

// Clock source select codes
`define CCSS_SEL_PLL        4'h1
`define CCSS_SEL_RC8M       4'h2
`define CCSS_SEL_RC128K     4'h3
`define CCSS_SEL_LFXO_MSB   2'h1

// Start-up time select codes
`define CCSS_SUT_00         2'h0
`define CCSS_SUT_01         2'h1
`define CCSS_SUT_10         2'h2
`define CCSS_SUT_11         2'h3

// PLL control/status field positions
`define CCSS_PCS_LOCK_BIT   0
`define CCSS_PCS_EN_BIT     1
`define CCSS_PCS_LSM_BIT    7
`define CCSS_PCS_RESET      8'h00

// Delay counts, watchdog oscillator cycles
`define CCSS_WDT_NONE       16'h0000
`define CCSS_WDT_4MS        16'h0200
`define CCSS_WDT_64MS       16'h2000

// Delay counts, selected source cycles
`define CCSS_CK_NONE        16'h0000
`define CCSS_CK_6           16'h0006
`define CCSS_CK_14          16'h000E
`define CCSS_CK_1K          16'h0400
`define CCSS_CK_14_1K       16'h040E
`define CCSS_CK_14_16K      16'h400E
`define CCSS_CK_32K         16'h8000

// Clock dividers
`define CCSS_PLL_SYS_DIV_W  2
`define CCSS_RC_DIV8_W      3

`endif

// >>> ccss_pkg.sv
/*
 * Types of the clock source select and start-up block.
 * Assumes ccss_defines.svh is on the include path.
 */
package ccss_pkg;

    typedef enum logic [1:0] {
        CCSS_RESET_DELAY,
        CCSS_RUN,
        CCSS_SLEEP,
        CCSS_WAKE_DELAY
    } ccss_mode_t;

    typedef struct packed {
        logic        low_speed_mode_bit;
        logic        enable;
        logic        lock;
    } ccss_pll_ctl_t;

    typedef struct packed {
        ccss_mode_t      mode;
        logic            ms_phase;
        logic [7:0]      cal;
        ccss_pll_ctl_t   pll;
        logic [1:0]      pll_div;
        logic [2:0]      rc_div;
        logic            ref_half;
        logic            sys_clk_en;
        logic            pll_ref_tick;
        logic            rc_osc_on;
        logic            pll_run;
        logic            cpu_run;
        logic            lsm_refused;
    } ccss_state_t;

    typedef struct packed {
        logic        clear;
        logic [15:0] count;
        logic        done;
    } ccss_cnt_state_t;

endpackage

// >>> ccss_delay_counter.sv
/*
 * Start-up delay counter: counts tick enables up to a target.
 * Assumes one clock; i_tick is a one-cycle enable from an oscillator.
 */
`timescale 1ns/1ps
`include "ccss_defines.svh"

module ccss_delay_counter (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // Control
    input  wire logic        i_clear,
    input  wire logic        i_tick,
    input  wire logic [15:0] i_target,
    // Status
    output logic             o_done
);
    ccss_pkg::ccss_cnt_state_t st;
    ccss_pkg::ccss_cnt_state_t next_st;

    always_comb begin
        next_st = st;
        if (i_clear) begin
            next_st.count = 16'h0000;
        end else if (i_tick && (st.count < i_target)) begin
            next_st.count = st.count + 16'h0001;
        end
        next_st.done  = !i_clear && (next_st.count >= i_target);
        next_st.clear = i_clear;
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_done = st.done;
endmodule

// >>> ccss_top.sv
/*
 * Clock source selection and start-up delay control.
 * Fuse codes choose PLL, 8 MHz RC, 128 kHz RC or watch crystal as system
 * clock; reset and wake-up delays are counted before the CPU may run.
 * Assumes oscillators appear as one-cycle tick enables synchronous to
 * i_clk, fuses are static levels, and sleep requests come from the core.
 */
//
// Summary of operation
// - PLL multiplies its 8 MHz RC reference by eight, 64 MHz nominal.
// - PLL runs only with source code 0001 and PLL enable set.
// - Power-down and standby switch off the RC oscillator and PLL.
// - Low speed mode feeds PLL the RC output halved, 32 MHz; not reached here, the PLL runs only with code 0001, where the bit is refused.
// - Low speed mode write refused while PLL drives the system clock.
// - Lock flag set once PLL reports lock.
// - Source code 0001 gives PLL output divided by four as system clock.
// - PLL start-up: 14CK plus 1K/16K plus 4/64 ms; reset delay 4 ms.
// - Source code 0010 selects calibrated 8 MHz RC, the default.
// - Divide-by-eight fuse divides the RC system clock by eight.
// - Every reset loads factory calibration into the calibration register.
// - RC start-up 6 CK; reset delay 14CK, +4 ms or +64 ms by code.
// - Reset-pin-disable fuse stretches the 14CK reset delay by 4 ms.
// - Reset time-out always timed by the watchdog oscillator.
// - Source code 0011 selects the 128 kHz oscillator.
// - 128 kHz start-up 6 CK; reset delay 14CK, +4 ms or +64 ms.
// - Source codes 01xx select the 32.768 kHz watch crystal.
// - Crystal start-up 1K/1K/32K CK with 4/64/64 ms reset delay.
// - Start-up cycle delays count cycles of the selected source.
// - Millisecond delays count 512 or 8192 watchdog oscillator cycles.
`timescale 1ns/1ps
`include "ccss_defines.svh"

module ccss_top (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    // Fuses, high means programmed
    input  wire logic [3:0] i_clock_source_select,
    input  wire logic [1:0] i_startup_time_select,
    input  wire logic       i_divide_by_eight_fuse,
    input  wire logic       i_reset_pin_disable_fuse,
    input  wire logic [7:0] i_factory_cal,
    // Oscillator tick enables
    input  wire logic       i_rc_tick,
    input  wire logic       i_lf128_tick,
    input  wire logic       i_xtal32_tick,
    input  wire logic       i_pll_tick,
    input  wire logic       i_wdt_tick,
    input  wire logic       i_pll_locked,
    // Sleep request, power-down or standby
    input  wire logic       i_deep_sleep,
    // Software writes
    input  wire logic       i_pcs_wr,
    input  wire logic [7:0] i_pcs_wdata,
    input  wire logic       i_cal_wr,
    input  wire logic [7:0] i_cal_wdata,
    // Status and clock control
    output logic [7:0]      o_pll_control_status,
    output logic [7:0]      o_osc_calibration_value,
    output logic            o_rc_osc_on,
    output logic            o_pll_run,
    output logic            o_pll_ref_tick,
    output logic            o_sys_clk_en,
    output logic            o_cpu_run,
    output logic            o_lsm_refused
);

    ////////////////////////////////////////////////////////////////////////
    // Source decode

    // Codes outside the four sources give no tick: no system clock,
    // and a delay that needs source cycles never ends
    logic sel_pll;
    logic sel_rc;
    logic sel_128k;
    logic sel_xtal;
    logic src_tick;

    assign sel_pll  = (i_clock_source_select == `CCSS_SEL_PLL);
    assign sel_rc   = (i_clock_source_select == `CCSS_SEL_RC8M);
    assign sel_128k = (i_clock_source_select == `CCSS_SEL_RC128K);
    assign sel_xtal = (i_clock_source_select[3:2] == `CCSS_SEL_LFXO_MSB);

    // Undivided tick of the selected source
    always_comb begin
        src_tick = 1'b0;
        if (sel_pll) begin
            src_tick = i_pll_tick;
        end else if (sel_rc) begin
            src_tick = i_rc_tick;
        end else if (sel_128k) begin
            src_tick = i_lf128_tick;
        end else if (sel_xtal) begin
            src_tick = i_xtal32_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Delay targets

    // Reset: millisecond phase first, then source cycles
    // Wake-up reuses both phases with its own targets
    // A zero target costs a cycle or two, never a tick
    // Reserved start-up code 11 falls through to the longest delay
    logic        is_reset_delay;
    logic [15:0] ms_target;
    logic [15:0] ck_target;

    always_comb begin
        ms_target = `CCSS_WDT_NONE;
        ck_target = `CCSS_CK_NONE;
        if (sel_pll) begin
            if (is_reset_delay) begin
                ms_target = `CCSS_WDT_4MS;
            end else begin
                ms_target = i_startup_time_select[1] ? `CCSS_WDT_64MS
                                                     : `CCSS_WDT_4MS;
                ck_target = i_startup_time_select[0] ? `CCSS_CK_14_16K
                                                     : `CCSS_CK_14_1K;
            end
        end else if (sel_xtal) begin
            ck_target = (i_startup_time_select[1]) ? `CCSS_CK_32K
                                                   : `CCSS_CK_1K;
            if (is_reset_delay) begin
                ms_target = (i_startup_time_select == `CCSS_SUT_00)
                            ? `CCSS_WDT_4MS : `CCSS_WDT_64MS;
            end
        end else begin
            if (is_reset_delay) begin
                ck_target = `CCSS_CK_14;
                case (i_startup_time_select)
                    `CCSS_SUT_00: begin
                        ms_target = i_reset_pin_disable_fuse
                                    ? `CCSS_WDT_4MS : `CCSS_WDT_NONE;
                    end
                    `CCSS_SUT_01: begin
                        ms_target = `CCSS_WDT_4MS;
                    end
                    default: begin
                        ms_target = `CCSS_WDT_64MS;
                    end
                endcase
            end else begin
                ck_target = `CCSS_CK_6;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State

    ccss_pkg::ccss_state_t st;
    ccss_pkg::ccss_state_t next_st;
    logic                  cnt_clear;
    logic                  cnt_tick;
    logic [15:0]           cnt_target;
    logic                  cnt_done;

    assign is_reset_delay = (st.mode == ccss_pkg::CCSS_RESET_DELAY);
    // Milliseconds from the watchdog oscillator, cycles from the source
    assign cnt_tick   = st.ms_phase ? i_wdt_tick : src_tick;
    assign cnt_target = st.ms_phase ? ms_target : ck_target;

    ccss_delay_counter u_delay (
        .i_clk    (i_clk),
        .i_sys_rst(i_sys_rst),
        .i_clear  (cnt_clear),
        .i_tick   (cnt_tick),
        .i_target (cnt_target),
        .o_done   (cnt_done)
    );

    // One counter for both phases, cleared at every phase change
    // so a done left from the previous phase is never seen
    always_comb begin
        next_st             = st;
        cnt_clear           = 1'b0;
        next_st.lsm_refused = 1'b0;

        // Start-up sequencing
        case (st.mode)
            ccss_pkg::CCSS_RESET_DELAY,
            ccss_pkg::CCSS_WAKE_DELAY: begin
                if (cnt_done) begin
                    cnt_clear = 1'b1;
                    if (st.ms_phase) begin
                        next_st.ms_phase = 1'b0;
                    end else begin
                        next_st.mode = ccss_pkg::CCSS_RUN;
                    end
                end
            end
            ccss_pkg::CCSS_RUN: begin
                if (i_deep_sleep) begin
                    next_st.mode = ccss_pkg::CCSS_SLEEP;
                end
            end
            ccss_pkg::CCSS_SLEEP: begin
                if (!i_deep_sleep) begin
                    next_st.mode     = ccss_pkg::CCSS_WAKE_DELAY;
                    next_st.ms_phase = 1'b1;
                    cnt_clear        = 1'b1;
                end
            end
            default: begin
                next_st.mode = ccss_pkg::CCSS_RESET_DELAY;
            end
        endcase

        // Software access
        if (i_cal_wr) begin
            next_st.cal = i_cal_wdata;
        end
        // Refused low speed request still lets the enable bit
        // of the same write take effect
        if (i_pcs_wr) begin
            next_st.pll.enable = i_pcs_wdata[`CCSS_PCS_EN_BIT];
            if (sel_pll && i_pcs_wdata[`CCSS_PCS_LSM_BIT]) begin
                next_st.pll.low_speed_mode_bit     = 1'b0;
                next_st.lsm_refused = 1'b1;
            end else begin
                next_st.pll.low_speed_mode_bit = i_pcs_wdata[`CCSS_PCS_LSM_BIT];
            end
        end

        // Oscillator and PLL power
        // Taken from the next mode so oscillator, PLL and lock
        // all drop on the edge that enters sleep
        next_st.rc_osc_on = (next_st.mode != ccss_pkg::CCSS_SLEEP);
        next_st.pll_run   = sel_pll && next_st.pll.enable
                            && next_st.rc_osc_on;
        // Lock never survives a PLL stop; it must be regained
        next_st.pll.lock  = next_st.pll_run && i_pll_locked;

        // PLL reference, full or halved RC clock
        // Halving keeps its own toggle, apart from the system divider
        next_st.pll_ref_tick = 1'b0;
        if (st.pll_run && i_rc_tick) begin
            next_st.ref_half = !st.ref_half;
            next_st.pll_ref_tick = !st.pll.low_speed_mode_bit || st.ref_half;
        end

        // System clock enable
        // Dividers keep counting in the delay states and hold in sleep, so the enable phase
        // after wake-up is arbitrary; only the rate is fixed
        next_st.sys_clk_en = 1'b0;
        if (sel_pll && st.pll_run && i_pll_tick) begin
            next_st.pll_div    = st.pll_div + 2'h1;
            next_st.sys_clk_en = (st.pll_div == 2'h3);
        end else if (sel_rc && st.rc_osc_on && i_rc_tick) begin
            next_st.rc_div     = st.rc_div + 3'h1;
            next_st.sys_clk_en = !i_divide_by_eight_fuse
                                 || (st.rc_div == 3'h7);
        end else if ((sel_128k && i_lf128_tick)
                     || (sel_xtal && i_xtal32_tick)) begin
            next_st.sys_clk_en = 1'b1;
        end
        if (next_st.mode != ccss_pkg::CCSS_RUN) begin
            next_st.sys_clk_en = 1'b0;
        end

        // CPU runs only in the run state
        next_st.cpu_run = (next_st.mode == ccss_pkg::CCSS_RUN);
    end

    // Calibration and enable reload on every reset cycle, so a
    // held reset follows a changing factory byte
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st            <= '0;
            st.mode       <= ccss_pkg::CCSS_RESET_DELAY;
            st.ms_phase   <= 1'b1;
            st.cal        <= i_factory_cal;
            st.pll.enable <= sel_pll;
            st.rc_osc_on  <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    always_comb begin
        // Unused status bits read as zero
        o_pll_control_status                      = `CCSS_PCS_RESET;
        o_pll_control_status[`CCSS_PCS_LOCK_BIT]  = st.pll.lock;
        o_pll_control_status[`CCSS_PCS_EN_BIT]    = st.pll.enable;
        o_pll_control_status[`CCSS_PCS_LSM_BIT]   = st.pll.low_speed_mode_bit;
    end

    assign o_osc_calibration_value = st.cal;
    assign o_rc_osc_on             = st.rc_osc_on;
    assign o_pll_run               = st.pll_run;
    assign o_pll_ref_tick          = st.pll_ref_tick;
    assign o_sys_clk_en            = st.sys_clk_en;
    assign o_cpu_run               = st.cpu_run;
    assign o_lsm_refused           = st.lsm_refused;
endmodule

// >>> ccss_top_asserts.sv
/*
 * Port checker of the clock source select and start-up block.
 * Assumes it is bound to ccss_top by the bench, one clock domain.
 */
`timescale 1ns/1ps
`include "ccss_defines.svh"

module ccss_top_asserts (
    // Watched inputs
    input wire logic       i_clk,
    input wire logic       i_sys_rst,
    input wire logic [3:0] i_clock_source_select,
    input wire logic       i_divide_by_eight_fuse,
    input wire logic [7:0] i_factory_cal,
    input wire logic       i_rc_tick,
    input wire logic       i_pll_locked,
    input wire logic       i_deep_sleep,
    input wire logic       i_pcs_wr,
    input wire logic [7:0] i_pcs_wdata,
    input wire logic       i_cal_wr,
    input wire logic [7:0] i_cal_wdata,
    // Watched outputs
    input wire logic [7:0] o_pll_control_status,
    input wire logic [7:0] o_osc_calibration_value,
    input wire logic       o_rc_osc_on,
    input wire logic       o_pll_run,
    input wire logic       o_pll_ref_tick,
    input wire logic       o_sys_clk_en,
    input wire logic       o_cpu_run,
    input wire logic       o_lsm_refused
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    wire logic is_pll = i_clock_source_select == `CCSS_SEL_PLL;
    wire logic is_rc  = i_clock_source_select == `CCSS_SEL_RC8M;

    a_cal_reset: assert property (disable iff (1'b0)
        i_sys_rst |=> o_osc_calibration_value == $past(i_factory_cal))
        else $error("cal not loaded");
    a_cal_write: assert property (
        i_cal_wr |=> o_osc_calibration_value == $past(i_cal_wdata)) else $error("cal not written");
    a_pll_gate: assert property (
        o_pll_run |-> is_pll && o_pll_control_status[1]) else $error("pll runs ungated");
    a_sleep_off: assert property (
        i_deep_sleep && o_cpu_run |=> !(o_cpu_run || o_rc_osc_on || o_pll_run
        || o_pll_control_status[0])) else $error("sleep left clocks on");
    a_lsm_refuse: assert property (
        i_pcs_wr && i_pcs_wdata[7] && is_pll |=> o_lsm_refused && !o_pll_control_status[7])
        else $error("low speed write not refused");
    a_lock_run: assert property (
        o_pll_control_status[0] |-> o_pll_run) else $error("lock without pll");
    a_lock_set: assert property (
        (o_pll_run && i_pll_locked) [*3] |-> o_pll_control_status[0]) else $error("lock missing");
    a_rc_src: assert property (
        o_sys_clk_en && is_rc |-> $past(i_rc_tick)) else $error("rc clock without tick");
    a_div_eight: assert property (
        o_sys_clk_en && is_rc && i_divide_by_eight_fuse |=> !o_sys_clk_en [*7])
        else $error("rc divide wrong");
    a_pll_div: assert property (
        o_sys_clk_en && is_pll |=> !o_sys_clk_en [*3]) else $error("pll divide wrong");
    a_ref_rc: assert property (
        o_pll_ref_tick |-> $past(i_rc_tick)) else $error("pll reference without rc tick");
    a_reset_hold: assert property (
        $fell(i_sys_rst) |-> !o_cpu_run [*2]) else $error("cpu ran at reset release");

    c_refused: cover property (o_lsm_refused);
    c_cpu_start: cover property ($rose(o_cpu_run));
    c_locked: cover property ($rose(o_pll_control_status[0]));
endmodule

// >>> ccss_bench.sv
/*
 * Self-checking bench of ccss_top with a start-up delay model.
 * Assumes the design and checker files are compiled first.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin failures++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end

module ccss_bench;
    logic       clk = 1'b0, rst = 1'b1, div8 = 1'b0, rdis = 1'b0, locked = 1'b0;
    logic       sleep = 1'b0, pwr = 1'b0, cwr = 1'b0;
    logic [3:0] sel = 4'h2;
    logic [1:0] startup_time_select = 2'h0;
    logic [7:0] fcal = 8'h00, pwd = 8'h00, cwd = 8'h00, pcs, cal;
    logic [4:0] tk = 5'h00;
    logic       rc_on, prun, ref_t, sys_en, cpu, lsm_ref;
    logic [7:0] tbl [7] = '{8'h21, 8'h22, 8'h35, 8'h11, 8'h41, 8'h64, 8'h15};
    int         failures = 0, n_compared = 0, sys_cnt = 0, ref_cnt = 0, seed = 32'he16a, rv;

    always #5 clk = ~clk;
    always @(posedge clk) begin
        sys_cnt <= sys_cnt + int'(sys_en);
        ref_cnt <= ref_cnt + int'(ref_t);
    end

    ccss_top u_ccss_top (
        .i_clk(clk), .i_sys_rst(rst), .i_clock_source_select(sel),
        .i_startup_time_select(startup_time_select), .i_divide_by_eight_fuse(div8),
        .i_reset_pin_disable_fuse(rdis), .i_factory_cal(fcal), .i_rc_tick(tk[1]),
        .i_lf128_tick(tk[2]), .i_xtal32_tick(tk[3]), .i_pll_tick(tk[4]), .i_wdt_tick(tk[0]),
        .i_pll_locked(locked), .i_deep_sleep(sleep), .i_pcs_wr(pwr), .i_pcs_wdata(pwd),
        .i_cal_wr(cwr), .i_cal_wdata(cwd), .o_pll_control_status(pcs),
        .o_osc_calibration_value(cal), .o_rc_osc_on(rc_on), .o_pll_run(prun),
        .o_pll_ref_tick(ref_t), .o_sys_clk_en(sys_en), .o_cpu_run(cpu), .o_lsm_refused(lsm_ref)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Model of delay targets and clock rates
    function automatic int ms_of(input bit w);
        if (sel == 4'h1) return (w && startup_time_select[1]) ? 8192 : 512;
        if (w) return 0;
        if (sel[3:2] == 2'b01) return (startup_time_select == 2'h0) ? 512 : 8192;
        return (startup_time_select == 2'h0) ? (rdis ? 512 : 0) : ((startup_time_select == 2'h1) ? 512 : 8192);
    endfunction
    function automatic int ck_of(input bit w);
        if (sel == 4'h1) return w ? (startup_time_select[0] ? 16398 : 1038) : 0;
        if (sel[3:2] == 2'b01) return startup_time_select[1] ? 32768 : 1024;
        return w ? 6 : 14;
    endfunction
    function automatic int sb();
        return (sel == 4'h1) ? 4 : (sel[3:2] == 2'b01) ? 3 : (sel == 4'h3) ? 2 : 1;
    endfunction
    function automatic int ex_sys();
        return (sel == 4'h1) ? 4 : (sel == 4'h2 && div8) ? 2 : 16;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Stimulus tasks
    task automatic pulse(input int b, input int n);
        repeat (n) begin
            @(posedge clk) tk <= 5'h01 << b;
            @(posedge clk) tk <= 5'h00;
        end
    endtask
    task automatic startup(input int ms, input int ck);
        repeat (3) @(posedge clk);
        if (ms > 0) begin
            pulse(0, ms - 1);
            if (ck <= 1024) pulse(sb(), ck + 1);
            repeat (3) @(posedge clk);
            #1 `CHK("cpu_run ms", 1'b0, cpu)
            pulse(0, 1);
            repeat (3) @(posedge clk);
        end
        if (ck > 0) begin
            pulse(sb(), ck - 1);
            repeat (3) @(posedge clk);
            #1 `CHK("cpu_run ck", 1'b0, cpu)
            pulse(sb(), 1);
        end
        for (int i = 0; i < 8 && cpu !== 1'b1; i++) @(posedge clk);
        #1 `CHK("cpu_run", 1'b1, cpu)
    endtask
    task automatic do_reset(input logic [3:0] s, input logic [1:0] u, input logic r);
        rv = $random(seed);
        @(posedge clk) begin
            rst <= 1'b1; sel <= s; startup_time_select <= u; rdis <= r; div8 <= rv[0]; fcal <= rv[15:8];
        end
        repeat (20) @(posedge clk);
        #1 `CHK("cal reset", fcal, cal)
        `CHK("status reset", {6'h00, s == 4'h1, 1'b0}, pcs)
        `CHK("rc on", 1'b1, rc_on)
        @(posedge clk) rst <= 1'b0;
    endtask
    task automatic clk_count(input int ex, input int exr);
        repeat (4) @(posedge clk);
        #1 sys_cnt = 0;
        ref_cnt = 0;
        repeat (16) begin
            @(posedge clk) tk <= (5'h01 << sb()) | 5'h02;
            @(posedge clk) tk <= 5'h00;
        end
        repeat (3) @(posedge clk);
        #1 `CHK("sys clocks", ex, sys_cnt)
        if (exr >= 0) `CHK("pll refs", exr, ref_cnt)
    endtask
    task automatic wr_pcs(input logic [7:0] d);
        @(posedge clk) begin pwr <= 1'b1; pwd <= d; end
        @(posedge clk) pwr <= 1'b0;
        #1;
    endtask
    task automatic nap();
        @(posedge clk) sleep <= 1'b1;
        repeat (2) @(posedge clk);
        #1 `CHK("asleep", 4'h0, {cpu, rc_on, prun, pcs[0]})
        @(posedge clk) sleep <= 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("failures %0d compared %0d", failures, n_compared);
        if (failures == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        for (int i = 0; i < 7; i++) begin
            do_reset(tbl[i][7:4], tbl[i][3:2], tbl[i][1]);
            startup(ms_of(1'b0), ck_of(1'b0));
            clk_count(ex_sys(), (sel == 4'h1) ? 16 : 0);
            if (tbl[i][0]) begin
                nap();
                startup(ms_of(1'b1), ck_of(1'b1));
            end
        end
        wr_pcs(8'h82);
        `CHK("lsm refused", 9'h102, {lsm_ref, pcs})
        @(posedge clk) locked <= 1'b1;
        repeat (4) @(posedge clk);
        #1 `CHK("pll locked", 9'h103, {prun, pcs})
        wr_pcs(8'h00);
        `CHK("pll off", 9'h000, {prun, pcs})
        wr_pcs(8'h02);
        repeat (4) @(posedge clk);
        #1 `CHK("relock", 9'h103, {prun, pcs})
        nap();
        do_reset(4'h2, 2'h0, 1'b0);
        startup(0, 14);
        wr_pcs(8'h82);
        `CHK("lsm set", 10'h082, {lsm_ref, prun, pcs})
        clk_count(ex_sys(), 0);
        rv = $random(seed);
        @(posedge clk) begin cwr <= 1'b1; cwd <= rv[7:0]; end
        @(posedge clk) cwr <= 1'b0;
        #1 `CHK("cal write", rv[7:0], cal)
        tally_and_finish();
    end
    initial begin
        repeat (95000) @(posedge clk);
        failures++;
        tally_and_finish();
    end
endmodule

bind ccss_top ccss_top_asserts u_ccss_top_asserts (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_clock_source_select(i_clock_source_select),
    .i_divide_by_eight_fuse(i_divide_by_eight_fuse), .i_factory_cal(i_factory_cal),
    .i_rc_tick(i_rc_tick), .i_pll_locked(i_pll_locked), .i_deep_sleep(i_deep_sleep),
    .i_pcs_wr(i_pcs_wr), .i_pcs_wdata(i_pcs_wdata), .i_cal_wr(i_cal_wr),
    .i_cal_wdata(i_cal_wdata), .o_pll_control_status(o_pll_control_status),
    .o_osc_calibration_value(o_osc_calibration_value), .o_rc_osc_on(o_rc_osc_on),
    .o_pll_run(o_pll_run), .o_pll_ref_tick(o_pll_ref_tick), .o_sys_clk_en(o_sys_clk_en),
    .o_cpu_run(o_cpu_run), .o_lsm_refused(o_lsm_refused)
);
